// [sim/dcd_datapath_monitor.sv]
// Purpose: Port assertions for the datapath
// Assumes: Bound to dcd_datapath
// Notes: Latencies as handed over
`timescale 1ns/1ps
module dcd_datapath_monitor
(
   // Clock and inputs
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic [7:0] y_bus,
   input wire logic       external_latch_strobe,
   input wire logic [3:0] dst_sel,
   input wire logic       src_en,
   input wire logic [2:0] src_sel,
   input wire logic [7:0] disc_status,
   // Outputs
   input wire logic [7:0] d_bus,
   input wire logic       transceiver_drive_enable,
   input wire logic [7:0] tag_lines,
   input wire logic [7:0] ctl_bus_lines,
   input wire logic [7:0] sys_control,
   input wire logic [7:0] control_pulse
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   wire ld = external_latch_strobe;
   a_tag_load: assert property (ld && dst_sel == 4'h9 |=> tag_lines == $past(y_bus))
      else $error("tag latch missed load");
   a_bus_load: assert property (ld && dst_sel == 4'hA |=> ctl_bus_lines == $past(y_bus))
      else $error("drive bus latch missed load");
   a_tag_hold: assert property (!(ld && dst_sel == 4'h9) |=> $stable(tag_lines))
      else $error("tag latch changed without strobe");
   a_pulse_clear: assert property (!(ld && dst_sel == 4'h7) |=> control_pulse == 8'h00)
      else $error("control pulse outlived its strobe");
   a_den_on: assert property (sys_control[1] |=> transceiver_drive_enable)
      else $error("drive enable low with data phase");
   a_den_off: assert property (sys_control[1:0] == 2'h0 |=> !transceiver_drive_enable)
      else $error("drive enable high with both phases off");
   a_dbus_idle: assert property (!src_en |=> d_bus == 8'h00)
      else $error("input bus driven with no source");
   a_dstat_route: assert property (src_en && src_sel == 3'h5 && $stable(disc_status)
      && disc_status == $past(disc_status, 3) |=> d_bus == $past(disc_status))
      else $error("disc status not on input bus");
endmodule

// [sim/dcd_datapath_tb.sv]
// Purpose: Self-checking bench for the datapath
// Assumes: 20 MHz clock, sync reset
// Notes: Drive side comes from dcd_drive_model
`timescale 1ns/1ps
module dcd_datapath_tb;
   logic [7:0]  y_bus, d_bus, host_status, seek_unit, boot_data, disc_status, v;
   logic [7:0]  tag_lines, ctl_bus_lines, vector_addr, irq_vector;
   logic [7:0]  sys_control, bus_control, control_pulse;
   logic [15:0] dal_out, dal_in;
   logic [3:0]  dst_sel;
   logic [2:0]  src_sel;
   logic [5:0]  option_switches;
   logic        clk_sys, sys_rst, external_latch_strobe, src_en, host_dma_grant;
   logic        d_bus_valid, transceiver_drive_enable, read_data, read_clock;
   logic        host_bs7, host_sync, data_in_capture, dma_request, slave_selected;
   int          n_fail, n_checks;

   dcd_drive_model drv (.clk_sys(clk_sys), .read_clock(read_clock), .read_data(read_data),
      .disc_status(disc_status));
   dcd_datapath dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .y_bus(y_bus),
      .external_latch_strobe(external_latch_strobe), .dst_sel(dst_sel), .src_en(src_en),
      .src_sel(src_sel), .d_bus(d_bus), .d_bus_valid(d_bus_valid), .dal_in(dal_in),
      .dal_out(dal_out), .transceiver_drive_enable(transceiver_drive_enable),
      .host_bs7(host_bs7), .host_sync(host_sync), .host_dma_grant(host_dma_grant),
      .host_status(host_status), .dma_request(dma_request), .slave_selected(slave_selected),
      .data_in_capture(data_in_capture),
      .tag_lines(tag_lines), .ctl_bus_lines(ctl_bus_lines), .disc_status(disc_status),
      .seek_unit(seek_unit), .read_data(read_data), .read_clock(read_clock), .write_data(),
      .option_switches(option_switches), .boot_data(boot_data), .vector_addr(vector_addr),
      .irq_vector(irq_vector), .sys_control(sys_control), .bus_control(bus_control),
      .control_pulse(control_pulse));

   task automatic stop_test();
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] d, input logic [7:0] b);
      @(posedge clk_sys);
      #1 external_latch_strobe = 1'b1;
      dst_sel = d;
      y_bus = b;
      @(posedge clk_sys);
      #1 external_latch_strobe = 1'b0;
   endtask
   task automatic rd(input logic [2:0] s);
      @(posedge clk_sys);
      #1 src_en = 1'b1;
      src_sel = s;
      @(posedge clk_sys);
      #1 src_en = 1'b0;
      v = d_bus;
      chk(d_bus_valid, 1'b1);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_latches();
      wr(4'h9, 8'h5A);
      wr(4'hA, 8'hC3);
      wr(4'hB, 8'h81);
      wr(4'hF, 8'h7E);
      wr(4'h8, 8'hFF);
      chk(tag_lines, 8'h5A);
      chk(ctl_bus_lines, 8'hC3);
      chk({vector_addr, irq_vector}, 16'h817E);
      wr(4'h7, 8'h96);
      chk(control_pulse, 8'h96);
      @(posedge clk_sys);
      #1 chk(control_pulse, 8'h00);
   endtask
   task automatic t_host();
      wr(4'h2, 8'hAB);
      wr(4'h3, 8'hCD);
      wr(4'h0, 8'h12);
      wr(4'h1, 8'h34);
      wr(4'hC, 8'h02);
      @(posedge clk_sys);
      #1 chk(transceiver_drive_enable, 1'b1);
      chk(dal_out, 16'h1234);
      wr(4'hC, 8'h00);
      @(posedge clk_sys);
      #1 chk(transceiver_drive_enable, 1'b0);
      wr(4'hC, 8'h01);
      @(posedge clk_sys);
      #1 chk(transceiver_drive_enable, 1'b1);
      chk(dal_out, 16'hABCD);
      host_dma_grant = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 chk(transceiver_drive_enable, 1'b0);
      chk(dal_out, 16'h1234);
      host_dma_grant = 1'b1;
      wr(4'hC, 8'h00);
      wr(4'hE, 8'h01);
      @(posedge clk_sys);
      #1 chk({bus_control[0], dma_request}, 2'b11);
      wr(4'hE, 8'h00);
   endtask
   task automatic t_sources();
      rd(3'h3);
      chk(v, 8'h5A);
      rd(3'h5);
      chk(v, 8'h3C);
      rd(3'h6);
      chk(v, 8'hC3);
      rd(3'h7);
      chk(v, 8'h2B);
   endtask
   task automatic t_hostin();
      dal_in = 16'hFDC8;
      host_bs7 = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 host_sync = 1'b1;
      data_in_capture = 1'b1;
      @(posedge clk_sys);
      #1 data_in_capture = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 chk(slave_selected, 1'b1);
      rd(3'h0);
      chk(v, 8'hC8);
      rd(3'h1);
      chk(v, 8'hFD);
      rd(3'h2);
      chk(v, 8'hC8);
      host_sync = 1'b0;
      wr(4'hD, 8'h00);
      rd(3'h1);
      chk(v, 8'h00);
      #1 chk(slave_selected, 1'b0);
   endtask
   task automatic t_buffer();
      wr(4'h4, 8'hFE);
      wr(4'h5, 8'h03);
      wr(4'h6, 8'h11);
      wr(4'h6, 8'h22);
      wr(4'h4, 8'hFE);
      wr(4'h5, 8'h03);
      rd(3'h4);
      chk(v, 8'h11);
      rd(3'h4);
      chk(v, 8'h22);
   endtask
   task automatic t_disc();
      wr(4'h4, 8'h10);
      wr(4'h5, 8'h00);
      wr(4'hC, 8'h04);
      drv.send(8'hA5);
      drv.send(8'h3C);
      repeat (10) @(posedge clk_sys);
      wr(4'hC, 8'h00);
      wr(4'h4, 8'h10);
      wr(4'h5, 8'h00);
      rd(3'h4);
      chk(v, 8'hA5);
      rd(3'h4);
      chk(v, 8'h3C);
   endtask

   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Whole run needs well under 1000 cycles
   initial
   begin
      #100000;
      n_fail++;
      stop_test();
   end
   initial
   begin
      {sys_rst, external_latch_strobe, src_en, host_dma_grant} = 4'h9;
      {y_bus, dst_sel, src_sel, boot_data} = 23'h0;
      {dal_in, host_bs7, host_sync, data_in_capture} = 19'h0;
      {host_status, seek_unit, option_switches} = 22'h16B0EB;
      repeat (3) @(posedge clk_sys);
      #1 sys_rst = 1'b0;
      t_latches();
      t_host();
      t_sources();
      t_hostin();
      t_buffer();
      t_disc();
      stop_test();
   end
endmodule

bind dcd_datapath dcd_datapath_monitor mon (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .y_bus(y_bus), .external_latch_strobe(external_latch_strobe), .dst_sel(dst_sel),
   .src_en(src_en), .src_sel(src_sel), .disc_status(disc_status), .d_bus(d_bus),
   .transceiver_drive_enable(transceiver_drive_enable), .tag_lines(tag_lines),
   .ctl_bus_lines(ctl_bus_lines), .sys_control(sys_control), .control_pulse(control_pulse));

// [sim/dcd_drive_model.sv]
// Purpose: Drive side of the data and control cables
// Assumes: Read clock idles low between frames
// Notes: Data line shows the inverse of the last bit when idle
`timescale 1ns/1ps
module dcd_drive_model
(
   // Clock
   input wire logic  clk_sys,
   // Drive cables
   output logic       read_clock,
   output logic       read_data,
   output logic [7:0] disc_status
);
   initial
   begin
      read_clock = 1'b0;
      read_data = 1'b1;
      disc_status = 8'h3C;
   end
   // Data settles a cycle before each clock rise, msb first
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         @(posedge clk_sys);
         #1 read_data = b[i];
         @(posedge clk_sys);
         #1 read_clock = 1'b1;
         repeat (2) @(posedge clk_sys);
         #1 read_clock = 1'b0;
      end
      read_data = ~read_data;
   endtask
endmodule

// [verilog/dcd_consts.svh]
// Purpose : Named constants of the disc controller datapath
// Assumes : Included by its bare name
// Notes   : Definitions only
`ifndef DCD_CONSTS_SVH
`define DCD_CONSTS_SVH
// ==========================================================
// Input bus source codes
`define DCD_SRC_SLAVE    3'h0
`define DCD_SRC_DIN_HI   3'h1
`define DCD_SRC_DIN_LO   3'h2
`define DCD_SRC_HSTAT    3'h3
`define DCD_SRC_BUFFER   3'h4
`define DCD_SRC_DSTAT    3'h5
`define DCD_SRC_SEEK     3'h6
`define DCD_SRC_OPTBOOT  3'h7
// ==========================================================
// Output bus destination codes (code 8 loads nothing)
`define DCD_DST_DOUT_HI  4'h0
`define DCD_DST_DOUT_LO  4'h1
`define DCD_DST_DMA_HI   4'h2
`define DCD_DST_DMA_LO   4'h3
`define DCD_DST_BADR_LO  4'h4
`define DCD_DST_BADR_HI  4'h5
`define DCD_DST_BDATA    4'h6
`define DCD_DST_CPULSE   4'h7
`define DCD_DST_TAGS     4'h9
`define DCD_DST_DRVBUS   4'hA
`define DCD_DST_VECTOR   4'hB
`define DCD_DST_SYSCTL   4'hC
`define DCD_DST_RSTDIN   4'hD
`define DCD_DST_BUSCTL   4'hE
`define DCD_DST_IVEC     4'hF
// ==========================================================
// System control and host bus control bits
`define DCD_SC_ADDR_EN   0
`define DCD_SC_DATA_EN   1
`define DCD_SC_BITC_EN   2
`define DCD_SC_WR_EN     3
`define DCD_SC_SHR_RST   4
`define DCD_SC_BOOT_SEL  5
`define DCD_BC_DMA_REQ   0
// ==========================================================
// Buffer, slave decode and reset values
`define DCD_BUF_AW       10
`define DCD_BUF_DEPTH    1024
`define DCD_BADR_HI_W    2
`define DCD_BASE_ADDR    16'hFDC8
`define DCD_SLAVE_MASK   16'hFFE0
`define DCD_BYTE_ZERO    8'h00
`define DCD_WORD_ZERO    16'h0000
`define DCD_BADR_ZERO    10'h000
`define DCD_BADR_ONE     10'h001
`define DCD_CNT_ZERO     3'h0
`define DCD_CNT_ONE      3'h1
`define DCD_CNT_LAST     3'h7
`endif

// [verilog/dcd_datapath.sv]
// Purpose : Internal datapath of a microprogrammed disc controller
// Assumes : Microcode fields arrive on clk_sys; pins are asynchronous
// Notes   : All outputs are flops of the state struct
`timescale 1ns/1ps
`include "dcd_consts.svh"
module dcd_datapath
   import dcd_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // Microprocessor output bus and destination field
   input  wire logic [7:0]  y_bus,
   input  wire logic        external_latch_strobe,
   input  wire logic [3:0]  dst_sel,
   // Microprocessor input bus and source field
   input  wire logic        src_en,
   input  wire logic [2:0]  src_sel,
   output      logic [7:0]  d_bus,
   output      logic        d_bus_valid,
   // Host bus pins
   input  wire logic [15:0] dal_in,
   output      logic [15:0] dal_out,
   output      logic        transceiver_drive_enable,
   input  wire logic        host_bs7,
   input  wire logic        host_sync,
   input  wire logic        host_dma_grant,
   input  wire logic [7:0]  host_status,
   output      logic        dma_request,
   output      logic        slave_selected,
   // Bus reply detector
   input  wire logic        data_in_capture,
   // Drive control cable
   output      logic [7:0]  tag_lines,
   output      logic [7:0]  ctl_bus_lines,
   input  wire logic [7:0]  disc_status,
   input  wire logic [7:0]  seek_unit,
   // Drive data cable
   input  wire logic        read_data,
   input  wire logic        read_clock,
   output      logic        write_data,
   // Board options and firmware side data
   input  wire logic [5:0]  option_switches,
   input  wire logic [7:0]  boot_data,
   // Internal latches seen by the rest of the board
   output      logic [7:0]  vector_addr,
   output      logic [7:0]  irq_vector,
   output      logic [7:0]  sys_control,
   output      logic [7:0]  bus_control,
   output      logic [7:0]  control_pulse
);
   // ==========================================================
   // State and submodule carriers
   dcd_top_t  st_r;
   dcd_top_t  st_nxt;
   dcd_pins_t pins;

   dcd_ser_if ser ();
   dcd_ram_if ram ();

   logic data_out_high_load;
   logic data_out_low_load;
   logic dma_high_load;
   logic dma_low_load;
   logic buffer_addr_low_load;
   logic buffer_addr_high_load;
   logic buffer_data_load;
   logic control_pulse_load;
   logic drive_tag_load;
   logic drive_bus_load;
   logic vector_load;
   logic sys_ctl_load;
   logic reset_data_in;
   logic bus_ctl_load;
   logic irq_vector_load;
   logic slave_address_select;
   logic buffer_read_select;
   logic disc_status_select;
   logic option_boot_select;
   logic disc_reading;
   logic disc_writing;
   logic disc_busy;
   logic addr_phase;
   logic data_phase;
   logic sync_rise;
   logic rd_clock_rise;
   logic badr_inc;
   logic ram_we;
   logic [7:0] ram_wdata;

   dcd_shifter u_shifter (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .sp      (ser)
   );

   dcd_sector_ram u_ram (
      .clk_sys (clk_sys),
      .ram     (ram)
   );

   always_comb
   begin
      pins.dal         = dal_in;
      pins.bs7         = host_bs7;
      pins.sync        = host_sync;
      pins.dma_grant   = host_dma_grant;
      pins.host_status = host_status;
      pins.disc_status = disc_status;
      pins.seek_unit   = seek_unit;
      pins.option_sw   = option_switches;
      pins.rd_data     = read_data;
      pins.rd_clock    = read_clock;
   end

   // ==========================================================
   // Destination decode
   always_comb
   begin
      data_out_high_load    = 1'b0;
      data_out_low_load     = 1'b0;
      dma_high_load         = 1'b0;
      dma_low_load          = 1'b0;
      buffer_addr_low_load  = 1'b0;
      buffer_addr_high_load = 1'b0;
      buffer_data_load      = 1'b0;
      control_pulse_load    = 1'b0;
      drive_tag_load        = 1'b0;
      drive_bus_load        = 1'b0;
      vector_load           = 1'b0;
      sys_ctl_load          = 1'b0;
      reset_data_in         = 1'b0;
      bus_ctl_load          = 1'b0;
      irq_vector_load       = 1'b0;
      if (external_latch_strobe)
      begin
         if (dst_sel == `DCD_DST_DOUT_HI) data_out_high_load = 1'b1;
         else if (dst_sel == `DCD_DST_DOUT_LO) data_out_low_load = 1'b1;
         else if (dst_sel == `DCD_DST_DMA_HI) dma_high_load = 1'b1;
         else if (dst_sel == `DCD_DST_DMA_LO) dma_low_load = 1'b1;
         else if (dst_sel == `DCD_DST_BADR_LO) buffer_addr_low_load = 1'b1;
         else if (dst_sel == `DCD_DST_BADR_HI) buffer_addr_high_load = 1'b1;
         else if (dst_sel == `DCD_DST_BDATA) buffer_data_load = 1'b1;
         else if (dst_sel == `DCD_DST_CPULSE) control_pulse_load = 1'b1;
         else if (dst_sel == `DCD_DST_TAGS) drive_tag_load = 1'b1;
         else if (dst_sel == `DCD_DST_DRVBUS) drive_bus_load = 1'b1;
         else if (dst_sel == `DCD_DST_VECTOR) vector_load = 1'b1;
         else if (dst_sel == `DCD_DST_SYSCTL) sys_ctl_load = 1'b1;
         else if (dst_sel == `DCD_DST_RSTDIN) reset_data_in = 1'b1;
         else if (dst_sel == `DCD_DST_BUSCTL) bus_ctl_load = 1'b1;
         else if (dst_sel == `DCD_DST_IVEC) irq_vector_load = 1'b1;
      end
   end

   // ==========================================================
   // Source decode: one-hot by construction
   always_comb
   begin
      slave_address_select = src_en && (src_sel == `DCD_SRC_SLAVE);
      buffer_read_select   = src_en && (src_sel == `DCD_SRC_BUFFER);
      disc_status_select   = src_en && (src_sel == `DCD_SRC_DSTAT);
      option_boot_select   = src_en && (src_sel == `DCD_SRC_OPTBOOT);
   end

   // ==========================================================
   // Mode terms and buffer port
   always_comb
   begin
      disc_reading  = st_r.sysctl[`DCD_SC_BITC_EN] && !st_r.sysctl[`DCD_SC_WR_EN];
      disc_writing  = st_r.sysctl[`DCD_SC_WR_EN];
      // Firmware access to the buffer is locked out during a disc pass
      disc_busy     = st_r.sysctl[`DCD_SC_BITC_EN] || disc_writing;
      // Address drive only while this controller owns the bus for DMA
      addr_phase    = st_r.sysctl[`DCD_SC_ADDR_EN] && st_r.s2.dma_grant;
      data_phase    = st_r.sysctl[`DCD_SC_DATA_EN];
      sync_rise     = st_r.s2.sync && !st_r.sync_d;
      rd_clock_rise = st_r.s2.rd_clock && !st_r.rd_clock_d;
      ram_we        = 1'b0;
      ram_wdata     = st_r.bdata;
      if (disc_reading && ser.byte_ready)
      begin
         ram_we    = 1'b1;
         ram_wdata = ser.hold;
      end
      else if (st_r.bdata_pend && !disc_busy)
      begin
         ram_we    = 1'b1;
      end
      badr_inc = ram_we
               || (disc_writing && ser.take)
               || (buffer_read_select && !disc_busy);
   end

   assign ram.we         = ram_we;
   assign ram.addr       = st_r.badr;
   assign ram.wdata      = ram_wdata;

   assign ser.shift      = rd_clock_rise && st_r.sysctl[`DCD_SC_BITC_EN];
   assign ser.ser_in     = st_r.s2.rd_data & st_r.sysctl[`DCD_SC_BITC_EN];
   assign ser.clear      = st_r.sysctl[`DCD_SC_SHR_RST];
   assign ser.write_mode = disc_writing;
   assign ser.par_in     = ram.rdata;

   // ==========================================================
   // Next state
   always_comb
   begin
      st_nxt            = st_r;
      st_nxt.s1         = pins;
      st_nxt.s2         = st_r.s1;
      st_nxt.rd_clock_d = st_r.s2.rd_clock;
      st_nxt.sync_d     = st_r.s2.sync;
      st_nxt.cpulse     = `DCD_BYTE_ZERO;
      st_nxt.dbus_valid = src_en;

      // Latches other than the control pulse hold until their own strobe
      if (data_out_high_load) st_nxt.dout[15:8] = y_bus;
      if (data_out_low_load) st_nxt.dout[7:0] = y_bus;
      if (dma_high_load) st_nxt.dma_addr[15:8] = y_bus;
      if (dma_low_load) st_nxt.dma_addr[7:0] = y_bus;
      if (control_pulse_load) st_nxt.cpulse = y_bus;
      if (drive_tag_load) st_nxt.tags = y_bus;
      if (drive_bus_load) st_nxt.drvbus = y_bus;
      if (vector_load) st_nxt.vector = y_bus;
      if (sys_ctl_load) st_nxt.sysctl = y_bus;
      if (bus_ctl_load) st_nxt.busctl = y_bus;
      if (irq_vector_load) st_nxt.ivec = y_bus;

      // Host data in: reply capture wins over a clear in the same cycle
      if (reset_data_in) st_nxt.din = `DCD_WORD_ZERO;
      if (data_in_capture) st_nxt.din = st_r.s2.dal;

      // Buffer data latch, written to the buffer one cycle later
      if (ram_we && !(disc_reading && ser.byte_ready)) st_nxt.bdata_pend = 1'b0;
      if (disc_busy) st_nxt.bdata_pend = 1'b0;
      if (buffer_data_load)
      begin
         st_nxt.bdata      = y_bus;
         st_nxt.bdata_pend = 1'b1;
      end

      // Buffer address counter: a preset overrides the advance only in the bits it loads
      if (badr_inc) st_nxt.badr = st_r.badr + `DCD_BADR_ONE;
      if (buffer_addr_low_load) st_nxt.badr[7:0] = y_bus;
      if (buffer_addr_high_load)
      begin
         st_nxt.badr[`DCD_BUF_AW-1:8] = y_bus[`DCD_BADR_HI_W-1:0];
      end

      // Slave address capture at the start of each host cycle
      if (sync_rise)
      begin
         st_nxt.slave_addr = st_r.s2.dal[7:0];
         st_nxt.slave_hit  = st_r.s2.bs7
            && ((st_r.s2.dal & `DCD_SLAVE_MASK) == (`DCD_BASE_ADDR & `DCD_SLAVE_MASK));
      end
      else if (!st_r.s2.sync)
      begin
         st_nxt.slave_hit = 1'b0;
      end

      // Input bus multiplexer
      st_nxt.dbus = `DCD_BYTE_ZERO;
      if (slave_address_select) st_nxt.dbus = st_r.slave_addr;
      else if (src_en && src_sel == `DCD_SRC_DIN_HI) st_nxt.dbus = st_r.din[15:8];
      else if (src_en && src_sel == `DCD_SRC_DIN_LO) st_nxt.dbus = st_r.din[7:0];
      else if (src_en && src_sel == `DCD_SRC_HSTAT) st_nxt.dbus = st_r.s2.host_status;
      else if (buffer_read_select) st_nxt.dbus = ram.rdata;
      else if (disc_status_select) st_nxt.dbus = st_r.s2.disc_status;
      else if (src_en && src_sel == `DCD_SRC_SEEK) st_nxt.dbus = st_r.s2.seek_unit;
      else if (option_boot_select)
      begin
         // Shared select: the system control latch picks the component
         if (st_r.sysctl[`DCD_SC_BOOT_SEL]) st_nxt.dbus = boot_data;
         else st_nxt.dbus = {2'b00, st_r.s2.option_sw};
      end

      // Host transceivers, from the settled phase enables
      st_nxt.drive_en = addr_phase || data_phase;
      st_nxt.dal_out  = addr_phase ? st_r.dma_addr : st_r.dout;
      st_nxt.dma_req  = st_r.busctl[`DCD_BC_DMA_REQ];

      // Serial write data only while writing
      st_nxt.wdata = ser.ser_out && disc_writing;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign d_bus                    = st_r.dbus;
   assign d_bus_valid              = st_r.dbus_valid;
   assign dal_out                  = st_r.dal_out;
   assign transceiver_drive_enable = st_r.drive_en;
   assign dma_request              = st_r.dma_req;
   assign slave_selected           = st_r.slave_hit;
   assign tag_lines                = st_r.tags;
   assign ctl_bus_lines            = st_r.drvbus;
   assign write_data               = st_r.wdata;
   assign vector_addr              = st_r.vector;
   assign irq_vector               = st_r.ivec;
   assign sys_control              = st_r.sysctl;
   assign bus_control              = st_r.busctl;
   assign control_pulse            = st_r.cpulse;
endmodule

// [verilog/dcd_ifs.sv]
// Purpose : Carriers between the datapath and its submodules
// Assumes : One controller clock
// Notes   : No clocking blocks
`timescale 1ns/1ps
`include "dcd_consts.svh"
// ==========================================================
// Serial/parallel converter
interface dcd_ser_if;
   logic       shift;
   logic       ser_in;
   logic       clear;
   logic       write_mode;
   logic [7:0] par_in;
   logic       take;
   logic       byte_ready;
   logic [7:0] hold;
   logic       ser_out;
   modport sh  (input shift, ser_in, clear, write_mode, par_in,
                output take, byte_ready, hold, ser_out);
   modport ctl (output shift, ser_in, clear, write_mode, par_in,
                input take, byte_ready, hold, ser_out);
endinterface

// ==========================================================
// Sector buffer port
interface dcd_ram_if;
   logic                   we;
   logic [`DCD_BUF_AW-1:0] addr;
   logic [7:0]             wdata;
   logic [7:0]             rdata;
   modport mem  (input we, addr, wdata, output rdata);
   modport user (output we, addr, wdata, input rdata);
endinterface

// [verilog/dcd_pkg.sv]
// Purpose : Types of the disc controller datapath
// Assumes : dcd_consts.svh gives the widths
// Notes   : State of the datapath and of the shifter is one packed struct each
`include "dcd_consts.svh"
package dcd_pkg;
   // ==========================================================
   // Pins crossing into the controller clock
   typedef struct packed {
      logic [15:0] dal;
      logic        bs7;
      logic        sync;
      logic        dma_grant;
      logic [7:0]  host_status;
      logic [7:0]  disc_status;
      logic [7:0]  seek_unit;
      logic [5:0]  option_sw;
      logic        rd_data;
      logic        rd_clock;
   } dcd_pins_t;

   // ==========================================================
   // Shift register state
   typedef struct packed {
      logic [7:0] sreg;
      logic [2:0] cnt;
      logic [7:0] hold;
      logic       ready;
      logic       take;
      logic       ser_out;
   } dcd_shift_t;

   // ==========================================================
   // Datapath state
   typedef struct packed {
      dcd_pins_t                 s1;
      dcd_pins_t                 s2;
      logic                      rd_clock_d;
      logic                      sync_d;
      logic [15:0]               dout;
      logic [15:0]               dma_addr;
      logic [15:0]               din;
      logic [`DCD_BUF_AW-1:0]    badr;
      logic [7:0]                bdata;
      logic                      bdata_pend;
      logic [7:0]                tags;
      logic [7:0]                drvbus;
      logic [7:0]                vector;
      logic [7:0]                sysctl;
      logic [7:0]                busctl;
      logic [7:0]                ivec;
      logic [7:0]                cpulse;
      logic [7:0]                slave_addr;
      logic                      slave_hit;
      logic [7:0]                dbus;
      logic                      dbus_valid;
      logic                      drive_en;
      logic [15:0]               dal_out;
      logic                      wdata;
      logic                      dma_req;
   } dcd_top_t;
endpackage

// [verilog/dcd_sector_ram.sv]
// Purpose : Full-sector byte buffer
// Assumes : Write on the clock, read without it
// Notes   : Read data follows the address in the same cycle
`timescale 1ns/1ps
`include "dcd_consts.svh"
module dcd_sector_ram
   import dcd_pkg::*;
(
   // Clock
   input  wire logic   clk_sys,
   // Buffer port
   dcd_ram_if.mem      ram
);
   logic [7:0] mem_q [0:`DCD_BUF_DEPTH-1];

   always_ff @(posedge clk_sys)
   begin
      if (ram.we)
      begin
         mem_q[ram.addr] <= ram.wdata;
      end
   end

   assign ram.rdata = mem_q[ram.addr];
endmodule

// [verilog/dcd_shifter.sv]
// Purpose : Read/write shift register with read holding latch
// Assumes : One shift pulse per bit cell, on the controller clock
// Notes   : Most significant bit travels first
`timescale 1ns/1ps
`include "dcd_consts.svh"
module dcd_shifter
   import dcd_pkg::*;
(
   // Clock and reset
   input  wire logic   clk_sys,
   input  wire logic   sys_rst,
   // Converter port
   dcd_ser_if.sh       sp
);
   dcd_shift_t st_r;
   dcd_shift_t st_nxt;

   always_comb
   begin
      st_nxt       = st_r;
      st_nxt.ready = 1'b0;
      st_nxt.take  = 1'b0;
      if (sp.clear)
      begin
         st_nxt.sreg    = `DCD_BYTE_ZERO;
         st_nxt.cnt     = `DCD_CNT_ZERO;
         st_nxt.ser_out = 1'b0;
      end
      else if (sp.shift && sp.write_mode)
      begin
         // Byte boundary: take the next buffer byte
         if (st_r.cnt == `DCD_CNT_ZERO)
         begin
            st_nxt.ser_out = sp.par_in[7];
            st_nxt.sreg    = {sp.par_in[6:0], 1'b0};
            st_nxt.take    = 1'b1;
         end
         else
         begin
            st_nxt.ser_out = st_r.sreg[7];
            st_nxt.sreg    = {st_r.sreg[6:0], 1'b0};
         end
         st_nxt.cnt = st_r.cnt + `DCD_CNT_ONE;
      end
      else if (sp.shift)
      begin
         st_nxt.sreg = {st_r.sreg[6:0], sp.ser_in};
         st_nxt.cnt  = st_r.cnt + `DCD_CNT_ONE;
         // Holding latch frees the shifter for the next byte at once
         if (st_r.cnt == `DCD_CNT_LAST)
         begin
            st_nxt.hold  = {st_r.sreg[6:0], sp.ser_in};
            st_nxt.ready = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign sp.take       = st_r.take;
   assign sp.byte_ready = st_r.ready;
   assign sp.hold       = st_r.hold;
   assign sp.ser_out    = st_r.ser_out;
endmodule
